// File: core/csc_pkg.sv
// Overview of operation
// - Carry flag follows add/subtract carry or borrow
// - Trace trap after each instruction, not in handlers
// - Trace enable copied to pending at instruction start
// - Low flag: second operand unsigned-below first
// - Negative flag: second operand signed-below first
// - Zero flag set on equal compare
// - General flag reports add/subtract overflow
// - User bit selects user or supervisor stack
// - Any exception clears the user bit
// - User-mode user stack pointer access traps undefined
// - Maskable interrupts need local and global enable
// - Enable/disable instructions and status word writes change local enable
// - Global enable clears on interrupt, sets on return
// - Branch conditions evaluate the five status flags
// - Reset clears bits 0-11, local enable set
// - Warm reset saves old status into register two
// - Bits 4 and 8 zero, 12-15 reserved
// - Status bits change through affecting instructions and bus writes
// - Configuration cleared on reset, cache bits reserved
// - Wide dispatch select picks 16 or 32-bit entries
// - Short pair mode uses 16-bit halves, pairs return
// - Register pairs: low bits in lower-numbered register
package csc_pkg;

  // Status word bit positions
  localparam int PSW_C = 0;
  localparam int PSW_T = 1;
  localparam int PSW_L = 2;
  localparam int PSW_U = 3;
  localparam int PSW_F = 5;
  localparam int PSW_Z = 6;
  localparam int PSW_N = 7;
  localparam int PSW_E = 9;
  localparam int PSW_P = 10;
  localparam int PSW_I = 11;

  // Configuration word bit positions
  localparam int CFG_ED = 8;
  localparam int CFG_SR = 9;

  // Reset values and writable masks
  localparam logic [15:0] PSW_RESET = 16'h0200;
  localparam logic [15:0] PSW_WMASK = 16'h0EEF;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_WMASK = 16'h0300;

  // Register byte offsets on the bus
  localparam logic [3:0] OFS_PSW   = 4'h0;
  localparam logic [3:0] OFS_CFG   = 4'h4;
  localparam logic [3:0] OFS_SAVE  = 4'h8;
  localparam logic [3:0] OFS_STAT  = 4'hC;

  // Dispatch table entry sizes in bytes
  localparam logic [31:0] ENTRY_NARROW = 32'h0000_0002;
  localparam logic [31:0] ENTRY_WIDE   = 32'h0000_0004;
  localparam int NARROW_ADDR_W = 17;

  // Branch condition codes
  typedef enum logic [3:0] {
    CC_EQ = 4'h0, CC_NE = 4'h1, CC_CS = 4'h2, CC_CC = 4'h3,
    CC_HI = 4'h4, CC_LS = 4'h5, CC_GT = 4'h6, CC_LE = 4'h7,
    CC_FS = 4'h8, CC_FC = 4'h9, CC_LO = 4'hA, CC_HS = 4'hB,
    CC_LT = 4'hC, CC_GE = 4'hD, CC_UC = 4'hE, CC_NV = 4'hF
  } csc_cond_t;

  // Events from the core instruction flow
  typedef struct packed {
    logic        instr_start;
    logic        instr_end;
    logic        arith_upd;
    logic        carry;
    logic        overflow;
    logic        cmp_upd;
    logic [15:0] cmp_first;
    logic [15:0] cmp_second;
    logic        irq_enable_instr;
    logic        irq_disable_instr;
    logic        exc_take;
    logic        irq_take;
    logic        handler_done;
    logic        enter_user;
    logic        usp_access;
  } csc_core_ev_t;

  // Classic Wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } csc_wb_req_t;

endpackage

// File: core/csc_regs.sv
`timescale 1ns/1ps
module csc_regs (
  input  wire logic                 mclk_in,        // Core clock
  input  wire logic                 rst_in,         // Cold reset, sync high
  input  wire logic                 warm_rst_in,    // Warm reset pulse
  input  csc_pkg::csc_wb_req_t      wb_req_in,      // Wishbone request
  output logic [31:0]               wb_dat_out,     // Wishbone read data
  output logic                      wb_ack_out,     // Wishbone ack
  input  csc_pkg::csc_core_ev_t     ev_in,          // Core events
  input  wire logic                 irq_req_in,     // Maskable request
  input  wire logic                 nmi_req_in,     // Non-maskable request
  input  wire logic                 br_req_in,      // Branch evaluate strobe
  input  csc_pkg::csc_cond_t        br_cond_in,     // Branch condition
  input  wire logic [31:0]          dispatch_base_pointer_in, // Table base
  input  wire logic [7:0]           vector_in,      // Exception vector
  input  wire logic [31:0]          table_entry_in, // Entry read from table
  input  wire logic [31:0]          r13_in,         // Register 13
  input  wire logic [31:0]          ra_in,          // Return address reg
  input  wire logic [15:0]          pair_lo_in,     // Lower-numbered reg
  input  wire logic [15:0]          pair_hi_in,     // Higher-numbered reg
  output logic [15:0]               psw_out,        // Status word
  output logic [15:0]               cfg_out,        // Config word
  output logic                      use_user_stack_out, // Stack select
  output logic                      irq_accept_out, // Maskable accepted
  output logic                      nmi_accept_out, // Non-maskable accepted
  output logic                      trace_trap_out, // Trace trap pulse
  output logic                      undefined_instr_trap_out, // Undef trap
  output logic                      br_taken_out,   // Branch decision
  output logic                      br_valid_out,   // Decision valid
  output logic [15:0]               gp_register_two_out, // Warm save
  output logic                      wide_dispatch_select_out, // Entry width
  output logic                      short_pair_mode_out, // Short regs
  output logic [31:0]               entry_addr_out, // Table entry address
  output logic [31:0]               handler_addr_out, // Handler address
  output logic [31:0]               ext_ra_out,     // Extended return addr
  output logic [31:0]               pair_out        // Joined register pair
);
  import csc_pkg::*;

  // Block overview
  // This block holds the status word and the configuration word
  // Of the core, and turns core events into flag updates.
  // It has one clock and no clock enable.
  // Every register moves on every rising edge.
  //
  // Status word layout
  // Bit 0 is carry, written by add and subtract.
  // Bit 1 is trace enable, set by software only.
  // Bit 2 is the unsigned low flag of a compare.
  // Bit 3 is the user mode bit.
  // Bit 4 is constant zero.
  // Bit 5 is the general flag, used for overflow.
  // Bit 6 is the zero flag of a compare.
  // Bit 7 is the signed negative flag of a compare.
  // Bit 8 is constant zero.
  // Bit 9 is the local maskable enable.
  // Bit 10 is trace pending.
  // Bit 11 is the global maskable enable.
  // Bits 12 to 15 are reserved and read zero.
  //
  // Configuration word layout
  // Bit 8 selects wide dispatch table entries.
  // Bit 9 selects short register pairing.
  // All other bits read zero and ignore writes.
  //
  // Software access
  // Software reaches both words over classic Wishbone.
  // A request is seen on the first edge with cyc and stb.
  // Ack rises one cycle later and stands for one cycle.
  // The write lands on the edge at which ack is high.
  // Read data is captured on the first edge of a request.
  // It stands together with ack.
  // Only byte lanes 0 and 1 carry register bits.
  // The saved word and the handler status are read only.
  // Unmapped offsets answer with zero data.
  //
  // Event priority within one cycle
  // A software write is applied first.
  // Core events then override the bits they touch.
  // Disable wins over enable when both arrive.
  // Exception entry wins over a user mode request.
  // Interrupt entry wins over handler completion.
  //
  // Trace handling
  // Trace enable is copied into pending at instruction start.
  // The trap fires when pending is set at instruction end.
  // The copy and the end may share a cycle.
  // The next pending value is used then.
  // No trace trap is raised inside a handler.
  //
  // Handler tracking
  // Exception or interrupt entry marks the handler busy.
  // The user bit of the interrupted code is kept.
  // Handler completion restores that user bit.
  // Global enable is set to one as well.
  // Nested entry overwrites the kept user bit.
  // Software that nests must save it itself.
  //
  // Interrupt gating
  // A maskable request needs both enables.
  // The non-maskable request is always passed.
  // Both answers follow their requests by one cycle.
  //
  // Branch evaluation
  // The strobe samples the current flags.
  // The decision and its valid flag follow one cycle later.
  // Each stands for a single cycle.
  //
  // Dispatch addressing
  // Narrow entries are two bytes and hold a halfword index.
  // The handler address is that index shifted left by one.
  // This keeps handlers in the lowest 128K of space.
  // Wide entries are four bytes and hold a full address.
  //
  // Register pairing
  // The lower-numbered register carries the low half.
  // In short mode the return pair joins two 16-bit halves.
  // Register 13 then gives the upper half.
  //
  // Resets
  // Cold reset clears everything except local enable.
  // Warm reset copies the old status word first.
  // The copy survives the warm reset.
  // Warm reset leaves the bus slave alone.
  // A request in flight still gets its answer.
  //
  // Hazards
  // Events are single-cycle pulses from the core.
  // A held pulse is taken again on every edge.
  // A user stack access is judged on the current mode.
  // A mode change in the same cycle is not seen yet.

  logic [15:0] psw_r;
  logic [15:0] psw_nxt;
  logic [15:0] cfg_r;
  logic [15:0] save_r;
  logic        in_handler_r;
  logic        saved_user_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic        trace_r;
  logic        undef_r;
  logic        brt_r;
  logic        brv_r;
  logic        irq_acc_r;
  logic        nmi_acc_r;
  logic [31:0] entry_r;
  logic [31:0] handler_r;
  logic [31:0] ext_ra_r;
  logic [31:0] pair_r;
  logic        wb_hit;
  logic        wr_psw;
  logic        wr_cfg;
  logic [15:0] lane_mask;

  // Evaluate a branch condition against the flags
  function automatic logic cond_eval(input csc_cond_t c, input logic [15:0] p);
    logic r;
    r = 1'b0;
    case (c)
      CC_EQ:   r = p[PSW_Z];
      CC_NE:   r = !p[PSW_Z];
      CC_CS:   r = p[PSW_C];
      CC_CC:   r = !p[PSW_C];
      CC_HI:   r = p[PSW_L];
      CC_LS:   r = !p[PSW_L];
      CC_GT:   r = p[PSW_N];
      CC_LE:   r = !p[PSW_N];
      CC_FS:   r = p[PSW_F];
      CC_FC:   r = !p[PSW_F];
      CC_LO:   r = !p[PSW_L] && !p[PSW_Z];
      CC_HS:   r = p[PSW_L] || p[PSW_Z];
      CC_LT:   r = !p[PSW_N] && !p[PSW_Z];
      CC_GE:   r = p[PSW_N] || p[PSW_Z];
      CC_UC:   r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Join a register pair, low half from the lower-numbered register
  function automatic logic [31:0] pair_join(input logic [15:0] lo, input logic [15:0] hi);
    return {hi, lo};
  endfunction

  // Bus decode; writes land on the edge at which ack is high
  assign wb_hit    = wb_req_in.cyc && wb_req_in.stb && !ack_r;
  assign wr_psw    = wb_req_in.cyc && wb_req_in.stb && ack_r && wb_req_in.we
                     && (wb_req_in.adr == OFS_PSW);
  assign wr_cfg    = wb_req_in.cyc && wb_req_in.stb && ack_r && wb_req_in.we
                     && (wb_req_in.adr == OFS_CFG);
  assign lane_mask = {{8{wb_req_in.sel[1]}}, {8{wb_req_in.sel[0]}}};

  // Next status word: software write first, then core events over it
  always_comb begin
    psw_nxt = psw_r;
    if (wr_psw) begin
      psw_nxt = (psw_r & ~(lane_mask & PSW_WMASK))
              | (wb_req_in.dat[15:0] & lane_mask & PSW_WMASK);
    end
    if (ev_in.instr_start) begin
      psw_nxt[PSW_P] = psw_nxt[PSW_T];
    end
    if (ev_in.arith_upd) begin
      psw_nxt[PSW_C] = ev_in.carry;
      psw_nxt[PSW_F] = ev_in.overflow;
    end
    if (ev_in.cmp_upd) begin
      psw_nxt[PSW_L] = ev_in.cmp_second < ev_in.cmp_first;
      psw_nxt[PSW_N] = $signed(ev_in.cmp_second) < $signed(ev_in.cmp_first);
      psw_nxt[PSW_Z] = ev_in.cmp_second == ev_in.cmp_first;
    end
    if (ev_in.irq_enable_instr) begin
      psw_nxt[PSW_E] = 1'b1;
    end
    if (ev_in.irq_disable_instr) begin
      psw_nxt[PSW_E] = 1'b0;
    end
    if (ev_in.enter_user) begin
      psw_nxt[PSW_U] = 1'b1;
    end
    if (ev_in.handler_done) begin
      psw_nxt[PSW_I] = 1'b1;
      psw_nxt[PSW_U] = saved_user_r;
    end
    if (ev_in.exc_take || ev_in.irq_take) begin
      psw_nxt[PSW_U] = 1'b0;
    end
    if (ev_in.irq_take) begin
      psw_nxt[PSW_I] = 1'b0;
    end
    psw_nxt = psw_nxt & PSW_WMASK;
  end

  // Status word register; other bits hold unless an event touches them
  always_ff @(posedge mclk_in) begin
    if (rst_in || warm_rst_in) begin
      psw_r <= PSW_RESET;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  // Warm reset keeps the pre-reset status word
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      save_r <= 16'h0000;
    end else if (warm_rst_in) begin
      save_r <= psw_r;
    end
  end

  // Configuration word
  always_ff @(posedge mclk_in) begin
    if (rst_in || warm_rst_in) begin
      cfg_r <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= (cfg_r & ~(lane_mask & CFG_WMASK))
             | (wb_req_in.dat[15:0] & lane_mask & CFG_WMASK);
    end
  end

  // Handler tracking for trace suppression and mode restore
  always_ff @(posedge mclk_in) begin
    if (rst_in || warm_rst_in) begin
      in_handler_r <= 1'b0;
      saved_user_r <= 1'b0;
    end else if (ev_in.exc_take || ev_in.irq_take) begin
      in_handler_r <= 1'b1;
      saved_user_r <= psw_r[PSW_U];
    end else if (ev_in.handler_done) begin
      in_handler_r <= 1'b0;
    end
  end

  // Traps raised at instruction boundaries
  always_ff @(posedge mclk_in) begin
    if (rst_in || warm_rst_in) begin
      trace_r <= 1'b0;
      undef_r <= 1'b0;
    end else begin
      trace_r <= ev_in.instr_end && psw_nxt[PSW_P] && !in_handler_r;
      undef_r <= ev_in.usp_access && psw_r[PSW_U];
    end
  end

  // Interrupt acceptance
  always_ff @(posedge mclk_in) begin
    if (rst_in || warm_rst_in) begin
      irq_acc_r <= 1'b0;
      nmi_acc_r <= 1'b0;
    end else begin
      irq_acc_r <= irq_req_in && psw_r[PSW_E] && psw_r[PSW_I];
      nmi_acc_r <= nmi_req_in;
    end
  end

  // Branch decision one cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (rst_in || warm_rst_in) begin
      brt_r <= 1'b0;
      brv_r <= 1'b0;
    end else begin
      brv_r <= br_req_in;
      brt_r <= br_req_in && cond_eval(br_cond_in, psw_r);
    end
  end

  // Dispatch and register pairing
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      entry_r   <= 32'h0000_0000;
      handler_r <= 32'h0000_0000;
      ext_ra_r  <= 32'h0000_0000;
      pair_r    <= 32'h0000_0000;
    end else begin
      if (cfg_r[CFG_ED]) begin
        entry_r   <= dispatch_base_pointer_in + ENTRY_WIDE * {24'h00_0000, vector_in};
        handler_r <= table_entry_in;
      end else begin
        entry_r   <= dispatch_base_pointer_in + ENTRY_NARROW * {24'h00_0000, vector_in};
        handler_r <= {15'h0000, table_entry_in[15:0], 1'b0};
      end
      if (cfg_r[CFG_SR]) begin
        ext_ra_r <= pair_join(ra_in[15:0], r13_in[15:0]);
      end else begin
        ext_ra_r <= ra_in;
      end
      pair_r <= pair_join(pair_lo_in, pair_hi_in);
    end
  end

  // Bus slave: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_hit;
      if (wb_hit && !wb_req_in.we) begin
        case (wb_req_in.adr)
          OFS_PSW:  rdat_r <= {16'h0000, psw_r};
          OFS_CFG:  rdat_r <= {16'h0000, cfg_r};
          OFS_SAVE: rdat_r <= {16'h0000, save_r};
          OFS_STAT: rdat_r <= {30'h0000_0000, saved_user_r, in_handler_r};
          default:  rdat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Output drive
  assign wb_ack_out               = ack_r;
  assign wb_dat_out               = rdat_r;
  assign psw_out                  = psw_r;
  assign cfg_out                  = cfg_r;
  assign use_user_stack_out       = psw_r[PSW_U];
  assign irq_accept_out           = irq_acc_r;
  assign nmi_accept_out           = nmi_acc_r;
  assign trace_trap_out           = trace_r;
  assign undefined_instr_trap_out = undef_r;
  assign br_taken_out             = brt_r;
  assign br_valid_out             = brv_r;
  assign gp_register_two_out      = save_r;
  assign wide_dispatch_select_out = cfg_r[CFG_ED];
  assign short_pair_mode_out      = cfg_r[CFG_SR];
  assign entry_addr_out           = entry_r;
  assign handler_addr_out         = handler_r;
  assign ext_ra_out               = ext_ra_r;
  assign pair_out                 = pair_r;

endmodule

// File: sim/csc_regs_asserts.sv
`timescale 1ns/1ps
module csc_regs_asserts (
  input  wire logic                 mclk_in,      // Clock
  input  wire logic                 rst_in,       // Reset
  input  wire logic                 warm_rst_in,  // Warm reset
  input  csc_pkg::csc_wb_req_t      wb_req_in,    // Bus request
  input  wire logic                 wb_ack_out,   // Bus ack
  input  csc_pkg::csc_core_ev_t     ev_in,        // Core events
  input  wire logic                 irq_req_in,   // Irq request
  input  wire logic                 br_req_in,    // Branch strobe
  input  csc_pkg::csc_cond_t        br_cond_in,   // Branch code
  input  wire logic [15:0]          psw_out,      // Status
  input  wire logic [15:0]          cfg_out,      // Config
  input  wire logic                 use_user_stack_out, // Stack select
  input  wire logic                 irq_accept_out,     // Irq accepted
  input  wire logic                 undefined_instr_trap_out, // Undef trap
  input  wire logic                 br_taken_out,       // Branch taken
  input  wire logic                 br_valid_out,       // Branch valid
  input  wire logic [15:0]          gp_register_two_out // Warm copy
);
  import csc_pkg::*;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  logic [15:0] c1_r;
  logic [15:0] c2_r;
  // Compare operands of the previous cycle, taken on every edge
  always_ff @(posedge mclk_in) begin
    c1_r <= ev_in.cmp_first;
    c2_r <= ev_in.cmp_second;
  end

  // Bus request and its one-cycle answer
  sequence s_req;
    wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
  endsequence
  sequence s_ack;
    wb_ack_out ##1 !wb_ack_out;
  endsequence

  chk_ack_pulse: assert property (s_req |=> s_ack)
    else $error("bus ack is not a one-cycle answer");
  chk_cmp_flags: assert property (
    ev_in.cmp_upd && !warm_rst_in |=> psw_out[PSW_Z] == (c1_r == c2_r) &&
    psw_out[PSW_L] == (c2_r < c1_r) && psw_out[PSW_N] == ($signed(c2_r) < $signed(c1_r)))
    else $error("compare flags wrong");
  chk_arith_flags: assert property (
    ev_in.arith_upd && !warm_rst_in |=> psw_out[PSW_C] == $past(ev_in.carry) &&
    psw_out[PSW_F] == $past(ev_in.overflow))
    else $error("carry or overflow flag wrong");
  chk_fixed_zero: assert property (
    (psw_out & ~PSW_WMASK) == 16'h0000 && (cfg_out & ~CFG_WMASK) == 16'h0000)
    else $error("constant or reserved bit set");
  chk_warm_save: assert property (
    warm_rst_in |=> psw_out == PSW_RESET && cfg_out == CFG_RESET &&
    gp_register_two_out == $past(psw_out))
    else $error("warm reset result wrong");
  chk_irq_gate: assert property (
    !$past(rst_in) && !$past(warm_rst_in) |-> irq_accept_out ==
    ($past(irq_req_in) && $past(psw_out[PSW_E]) && $past(psw_out[PSW_I])))
    else $error("maskable accept ignores enables");
  chk_branch_eq: assert property (
    br_req_in && br_cond_in == CC_EQ |=> br_valid_out && br_taken_out == $past(psw_out[PSW_Z]))
    else $error("equal branch decision wrong");
  chk_exc_super: assert property (
    ev_in.exc_take |=> !psw_out[PSW_U] && !use_user_stack_out)
    else $error("exception left user mode set");
  chk_usp_trap: assert property (
    ev_in.usp_access |=> undefined_instr_trap_out == $past(psw_out[PSW_U]))
    else $error("user stack access trap wrong");
  chk_gie_clear: assert property (
    ev_in.irq_take && !ev_in.irq_enable_instr && !ev_in.irq_disable_instr &&
    !wb_req_in.we && !warm_rst_in |=> !psw_out[PSW_I] && $stable(psw_out[PSW_E]))
    else $error("interrupt entry enables wrong");
endmodule

bind csc_regs csc_regs_asserts u_chk (.mclk_in, .rst_in, .warm_rst_in, .wb_req_in,
  .wb_ack_out, .ev_in, .irq_req_in, .br_req_in, .br_cond_in, .psw_out, .cfg_out,
  .use_user_stack_out, .irq_accept_out, .undefined_instr_trap_out, .br_taken_out,
  .br_valid_out, .gp_register_two_out);

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import csc_pkg::*;
  // Design inputs, all set at time zero
  logic          mclk_in = 1'b0;
  logic          rst_in = 1'b1;
  logic          warm_rst_in = 1'b0;
  logic          irq_req_in = 1'b0;
  logic          nmi_req_in = 1'b0;
  logic          br_req_in = 1'b0;
  csc_cond_t     br_cond_in = CC_EQ;
  csc_wb_req_t   wb_req_in = '0;
  csc_core_ev_t  ev_in = '0;
  logic [31:0]   dispatch_base_pointer_in = '0, table_entry_in = '0, r13_in = '0, ra_in = '0;
  logic [7:0]    vector_in = '0;
  logic [15:0]   pair_lo_in = '0, pair_hi_in = '0;
  // Design outputs
  logic [31:0]   wb_dat_out, entry_addr_out, handler_addr_out, ext_ra_out, pair_out;
  logic [15:0]   psw_out, cfg_out, gp_register_two_out;
  logic          wb_ack_out, use_user_stack_out, irq_accept_out, nmi_accept_out;
  logic          trace_trap_out, undefined_instr_trap_out, br_taken_out, br_valid_out;
  logic          wide_dispatch_select_out, short_pair_mode_out;
  // Bench state
  logic [31:0]   rd;
  logic [15:0]   ep;
  csc_core_ev_t  e;
  int            n_mismatch = 0, n_checks = 0, n_cyc = 0;

  csc_regs uut (.mclk_in, .rst_in, .warm_rst_in, .wb_req_in, .wb_dat_out, .wb_ack_out, .ev_in,
    .irq_req_in, .nmi_req_in, .br_req_in, .br_cond_in, .dispatch_base_pointer_in, .vector_in,
    .table_entry_in, .r13_in, .ra_in, .pair_lo_in, .pair_hi_in, .psw_out, .cfg_out,
    .use_user_stack_out, .irq_accept_out, .nmi_accept_out, .trace_trap_out,
    .undefined_instr_trap_out, .br_taken_out, .br_valid_out, .gp_register_two_out,
    .wide_dispatch_select_out, .short_pair_mode_out, .entry_addr_out, .handler_addr_out,
    .ext_ra_out, .pair_out);

  // 200 MHz clock
  always #2.5 mclk_in = ~mclk_in;
  // Cut a hung run short
  always @(posedge mclk_in) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask

  // Classic bus cycle, held until ack is sampled
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge mclk_in);
    wb_req_in <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do @(posedge mclk_in); while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_req_in <= '0;
    @(negedge mclk_in);
  endtask

  // One cycle of events, then look at the settled outputs
  task automatic step(csc_core_ev_t ce, logic b, logic [3:0] c, logic w);
    @(posedge mclk_in);
    ev_in <= ce;
    br_req_in <= b;
    br_cond_in <= csc_cond_t'(c);
    warm_rst_in <= w;
    @(posedge mclk_in);
    ev_in <= '0;
    br_req_in <= 1'b0;
    warm_rst_in <= 1'b0;
    @(negedge mclk_in);
  endtask

  // Bits: start+end, exception, user entry, stack access, return, irq, enable, disable
  function automatic csc_core_ev_t f_ev(logic [7:0] m);
    f_ev = '0;
    {f_ev.instr_start, f_ev.exc_take, f_ev.enter_user, f_ev.usp_access} = m[7:4];
    {f_ev.handler_done, f_ev.irq_take, f_ev.irq_enable_instr, f_ev.irq_disable_instr} = m[3:0];
    f_ev.instr_end = m[7];
  endfunction

  function automatic logic [15:0] f_flags(logic [15:0] p, csc_core_ev_t v);
    p[PSW_C] = v.carry;
    p[PSW_F] = v.overflow;
    p[PSW_Z] = v.cmp_first == v.cmp_second;
    p[PSW_L] = v.cmp_second < v.cmp_first;
    p[PSW_N] = $signed(v.cmp_second) < $signed(v.cmp_first);
    return p;
  endfunction

  function automatic logic f_cond(logic [3:0] c, logic [15:0] p);
    logic [15:0] t;
    t = {1'b0, 1'b1, p[PSW_N] | p[PSW_Z], !p[PSW_N] & !p[PSW_Z], p[PSW_L] | p[PSW_Z],
         !p[PSW_L] & !p[PSW_Z], !p[PSW_F], p[PSW_F], !p[PSW_N], p[PSW_N], !p[PSW_L],
         p[PSW_L], !p[PSW_C], p[PSW_C], !p[PSW_Z], p[PSW_Z]};
    return t[c];
  endfunction

  // Main sequence
  initial begin
    void'($urandom(22));
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    chk("psw reset", psw_out, 16'h0200);
    chk("cfg reset", cfg_out, 16'h0000);
    wb(1'b1, OFS_PSW, 32'hFFFF_FFFF);
    chk("psw write", psw_out, 16'h0EEF);
    wb(1'b0, OFS_PSW, 32'h0000_0000);
    chk("psw read", rd, 32'h0000_0EEF);
    wb(1'b1, OFS_CFG, 32'hFFFF_FFFF);
    chk("cfg write", cfg_out, 16'h0300);
    wb(1'b1, OFS_SAVE, 32'hFFFF_FFFF);
    wb(1'b0, OFS_SAVE, 32'h0000_0000);
    chk("save ro", rd, 32'h0000_0000);
    wb(1'b0, 4'h2, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    wb(1'b1, OFS_PSW, 32'h0000_0200);
    ep = 16'h0200;
    for (int i = 0; i < 48; i++) begin
      e = '0;
      {e.cmp_upd, e.arith_upd, e.carry, e.overflow} = {2'b11, 2'($urandom)};
      e.cmp_first = (i == 0) ? 16'h8000 : 16'($urandom);
      e.cmp_second = (i == 1) ? e.cmp_first : (i == 0) ? 16'h7FFF : 16'($urandom);
      step(e, 1'b0, 4'h0, 1'b0);
      ep = f_flags(ep, e);
      chk("flags", psw_out, ep);
      step('0, 1'b1, i[3:0], 1'b0);
      chk("br valid", br_valid_out, 1'b1);
      chk("br taken", br_taken_out, f_cond(i[3:0], ep));
    end
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, OFS_CFG, 32'(k) << 8);
      @(posedge mclk_in);
      {dispatch_base_pointer_in, table_entry_in} <= {$urandom, $urandom};
      {r13_in, ra_in} <= {$urandom, $urandom};
      {vector_in, pair_lo_in, pair_hi_in} <= 40'({$urandom, $urandom});
      step('0, 1'b0, 4'h0, 1'b0);
      chk("wide", wide_dispatch_select_out, k[0]);
      chk("short", short_pair_mode_out, k[1]);
      chk("entry", entry_addr_out, dispatch_base_pointer_in +
          vector_in * (k[0] ? ENTRY_WIDE : ENTRY_NARROW));
      chk("handler", handler_addr_out,
          k[0] ? table_entry_in : {15'h0000, table_entry_in[15:0], 1'b0});
      chk("ext ra", ext_ra_out, k[1] ? {r13_in[15:0], ra_in[15:0]} : ra_in);
      chk("pair", pair_out, {pair_hi_in, pair_lo_in});
    end
    step('0, 1'b0, 4'h0, 1'b1);
    chk("warm save", gp_register_two_out, ep);
    chk("warm psw", psw_out, 16'h0200);
    chk("warm cfg", cfg_out, 16'h0000);
    wb(1'b1, OFS_PSW, 32'h0000_0202);
    step(f_ev(8'h80), 1'b0, 4'h0, 1'b0);
    chk("trace", trace_trap_out, 1'b1);
    chk("pending", psw_out[PSW_P], 1'b1);
    step(f_ev(8'h40), 1'b0, 4'h0, 1'b0);
    step(f_ev(8'h80), 1'b0, 4'h0, 1'b0);
    chk("trace hdl", trace_trap_out, 1'b0);
    step(f_ev(8'h18), 1'b0, 4'h0, 1'b0);
    chk("undef sup", undefined_instr_trap_out, 1'b0);
    step(f_ev(8'h20), 1'b0, 4'h0, 1'b0);
    chk("user stack", use_user_stack_out, 1'b1);
    step(f_ev(8'h10), 1'b0, 4'h0, 1'b0);
    chk("undef usr", undefined_instr_trap_out, 1'b1);
    step(f_ev(8'h40), 1'b0, 4'h0, 1'b0);
    chk("super", use_user_stack_out, 1'b0);
    wb(1'b1, OFS_PSW, 32'h0000_0200);
    @(posedge mclk_in);
    {irq_req_in, nmi_req_in} <= 2'h3;
    step('0, 1'b0, 4'h0, 1'b0);
    chk("irq masked", irq_accept_out, 1'b0);
    chk("nmi", nmi_accept_out, 1'b1);
    wb(1'b1, OFS_PSW, 32'h0000_0A00);
    step('0, 1'b0, 4'h0, 1'b0);
    chk("irq open", irq_accept_out, 1'b1);
    step(f_ev(8'h01), 1'b0, 4'h0, 1'b0);
    chk("disable", psw_out[PSW_E], 1'b0);
    step(f_ev(8'h02), 1'b0, 4'h0, 1'b0);
    chk("enable", psw_out[PSW_E], 1'b1);
    step(f_ev(8'h04), 1'b0, 4'h0, 1'b0);
    chk("irq entry", psw_out[11:9], 3'h1);
    step(f_ev(8'h08), 1'b0, 4'h0, 1'b0);
    chk("irq return", psw_out[PSW_I], 1'b1);
    stop_test();
  end
endmodule
